/* File: src/accum_exec.sv */
// Purpose: execute idle, or-with-register and the three accumulator moves
// Assumes: fetch stage offers one decoded instruction per clock while instr_valid is high
// Notes:   every instruction retires one clock after it is taken
`timescale 1ns/1ps
`default_nettype none
`include "accum_exec_regs.svh"

module accum_exec (
  input  wire logic                    clk,         // 40 MHz instruction clock
  input  wire logic                    resetn,      // async reset, active low
  input  wire logic                    instr_valid, // decoded instruction offered
  input  wire accum_exec_pkg::opcode_t instr_op,    // decoded operation
  input  wire logic [7:0]              instr_addr,  // register address 0..FFh
  input  wire logic                    instr_dest,  // destination select
  input  wire logic [7:0]              instr_lit,   // 8-bit literal
  input  wire logic [7:0]              dbg_addr,    // register peek address
  output logic                         instr_ready, // can take an instruction
  output logic                         retire,      // one-cycle completion pulse
  output logic [7:0]                   accum,       // accumulator
  output logic                         zero_flag,   // zero flag
  output logic [7:0]                   dbg_data     // registered peek data
);

  // ****************************************************
  // declarations
  // ****************************************************
  logic [7:0]                  acc_ff;
  logic                        zero_ff;
  logic                        retire_ff;
  logic [7:0]                  dbg_ff;
  logic                        ready_ff;
  logic [7:0]                  last_addr_ff;
  accum_exec_pkg::exec_state_t state_ff;
  logic [7:0]                  nxt_acc;
  logic                        nxt_zero;
  logic                        reg_wr;
  logic [7:0]                  reg_wdata;
  logic [7:0]                  reg_rdata;
  logic [7:0]                  dbg_rdata;
  logic [7:0]                  or_result;
  logic                        take;

  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == 8'h00);
  endfunction : is_zero

  assign take      = instr_valid && (state_ff == accum_exec_pkg::ST_READY);
  assign or_result = acc_ff | reg_rdata;

  // ****************************************************
  // register space
  // ****************************************************
  // second read port only for observation; shares the write port
  reg_space u_regs (
    .clk     (clk),
    .resetn  (resetn),
    .wr_en   (reg_wr),
    .wr_addr (instr_addr),
    .wr_data (reg_wdata),
    .rd_addr (instr_addr),
    .rd_data (reg_rdata)
  );

  reg_space u_shadow (
    .clk     (clk),
    .resetn  (resetn),
    .wr_en   (reg_wr),
    .wr_addr (instr_addr),
    .wr_data (reg_wdata),
    .rd_addr (dbg_addr),
    .rd_data (dbg_rdata)
  );

  // ****************************************************
  // execute decode
  // ****************************************************
  always_comb begin
    nxt_acc   = acc_ff;
    nxt_zero  = zero_ff;
    reg_wr    = 1'b0;
    reg_wdata = acc_ff;
    if (take) begin
      case (instr_op)
        accum_exec_pkg::OP_OR_ACCUM_WITH_REG: begin
          nxt_zero = is_zero(or_result);
          if (instr_dest == `DEST_ACCUM) begin
            nxt_acc = or_result;
          end else begin
            reg_wr    = 1'b1;
            reg_wdata = or_result;
          end
        end
        accum_exec_pkg::OP_MOVE_REG_TO_ACCUM: begin
          nxt_acc = reg_rdata;
        end
        accum_exec_pkg::OP_LOAD_LITERAL_TO_ACCUM: begin
          nxt_acc = instr_lit;
        end
        accum_exec_pkg::OP_MOVE_ACCUM_TO_REG: begin
          reg_wr    = 1'b1;
          reg_wdata = acc_ff;
        end
        accum_exec_pkg::OP_IDLE_INSTRUCTION: begin
          nxt_acc = acc_ff;
        end
        default: begin
          nxt_acc = acc_ff;
        end
      endcase
    end
  end

  // ****************************************************
  // state
  // ****************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc_ff  <= `ACC_RESET_VALUE;
      zero_ff <= `ZERO_RESET_VALUE;
    end else begin
      acc_ff  <= nxt_acc;
      zero_ff <= nxt_zero;
    end
  end

  // single state: every instruction takes one cycle, no stall
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= accum_exec_pkg::ST_READY;
    end else begin
      case (state_ff)
        accum_exec_pkg::ST_READY: state_ff <= accum_exec_pkg::ST_READY;
        default:                  state_ff <= accum_exec_pkg::ST_READY;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      retire_ff <= 1'b0;
    end else begin
      retire_ff <= take;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dbg_ff <= `REG_RESET_VALUE;
    end else begin
      dbg_ff <= dbg_rdata;
    end
  end

  // registered so the port comes straight from a flip-flop
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ready_ff <= 1'b1;
    end else begin
      ready_ff <= (state_ff == accum_exec_pkg::ST_READY);
    end
  end

  // address of the instruction just taken; the fetch stage moves on
  // before a write-back can be looked at through the read port
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      last_addr_ff <= 8'h00;
    end else begin
      last_addr_ff <= instr_addr;
    end
  end

  assign accum       = acc_ff;
  assign zero_flag   = zero_ff;
  assign retire      = retire_ff;
  assign dbg_data    = dbg_ff;
  assign instr_ready = ready_ff;

  // ****************************************************
  // checks
  // ****************************************************
  chk_or_to_accum: assert property (@(posedge clk) disable iff (!resetn)
    take && instr_op == accum_exec_pkg::OP_OR_ACCUM_WITH_REG && !instr_dest
    |=> accum == $past(acc_ff | reg_rdata))
    else $error("or to accumulator wrong");

  chk_or_to_reg: assert property (@(posedge clk) disable iff (!resetn)
    take && instr_op == accum_exec_pkg::OP_OR_ACCUM_WITH_REG && instr_dest
    |=> accum == $past(acc_ff) && u_regs.mem_ff[last_addr_ff] == $past(or_result))
    else $error("or to register wrong");

  chk_zero_flag: assert property (@(posedge clk) disable iff (!resetn)
    take && instr_op == accum_exec_pkg::OP_OR_ACCUM_WITH_REG
    |=> zero_flag == ($past(or_result) == 8'h00))
    else $error("zero flag wrong");

  chk_move_to_accum: assert property (@(posedge clk) disable iff (!resetn)
    take && instr_op == accum_exec_pkg::OP_MOVE_REG_TO_ACCUM
    |=> accum == $past(reg_rdata) && $stable(zero_flag))
    else $error("move to accumulator wrong");

  chk_literal_load: assert property (@(posedge clk) disable iff (!resetn)
    take && instr_op == accum_exec_pkg::OP_LOAD_LITERAL_TO_ACCUM
    |=> accum == $past(instr_lit) && $stable(zero_flag))
    else $error("literal load wrong");

  chk_move_to_reg: assert property (@(posedge clk) disable iff (!resetn)
    take && instr_op == accum_exec_pkg::OP_MOVE_ACCUM_TO_REG
    |=> u_regs.mem_ff[last_addr_ff] == $past(acc_ff) && $stable(accum) && $stable(zero_flag))
    else $error("move to register wrong");

  chk_idle_quiet: assert property (@(posedge clk) disable iff (!resetn)
    take && instr_op == accum_exec_pkg::OP_IDLE_INSTRUCTION
    |=> $stable(accum) && $stable(zero_flag) && retire)
    else $error("idle changed state");

  chk_one_cycle: assert property (@(posedge clk) disable iff (!resetn)
    take |=> retire ##1 (retire == $past(take)))
    else $error("retire not one cycle");

endmodule : accum_exec
`default_nettype wire

/* File: common/accum_exec_regs.svh */
// Purpose: constants for the accumulator move/or execute block
// Assumes: 8-bit data path, 256-entry register space
// Notes:   definitions only
`ifndef ACCUM_EXEC_REGS_SVH
`define ACCUM_EXEC_REGS_SVH

`define ACC_RESET_VALUE   8'h00
`define ZERO_RESET_VALUE  1'b0
`define REG_RESET_VALUE   8'h00
`define REG_ADDR_MAX      8'hFF
`define DEST_ACCUM        1'b0
`define DEST_REG          1'b1
`define EXEC_CYCLES       4'h1

`endif

/* File: common/accum_exec_pkg.sv */
// Purpose: types for the accumulator move/or execute block
// Assumes: opcodes arrive already decoded from the fetch stage
// Notes:   encodings are local to this block
`default_nettype none
package accum_exec_pkg;

  typedef enum logic [2:0] {
    OP_IDLE_INSTRUCTION      = 3'h0,
    OP_OR_ACCUM_WITH_REG     = 3'h1,
    OP_MOVE_REG_TO_ACCUM     = 3'h2,
    OP_LOAD_LITERAL_TO_ACCUM = 3'h3,
    OP_MOVE_ACCUM_TO_REG     = 3'h4
  } opcode_t;

  typedef enum logic [1:0] {
    ST_READY = 2'h0,
    ST_EXEC  = 2'h1
  } exec_state_t;

endpackage : accum_exec_pkg
`default_nettype wire

/* File: src/reg_space.sv */
// Purpose: 256 x 8 data-memory register space
// Assumes: one write port, one combinational read port
// Notes:   write takes effect at the clock edge
`timescale 1ns/1ps
`default_nettype none
`include "accum_exec_regs.svh"

module reg_space (
  input  wire logic       clk,     // instruction clock
  input  wire logic       resetn,  // async reset, active low
  input  wire logic       wr_en,   // write strobe
  input  wire logic [7:0] wr_addr, // write address
  input  wire logic [7:0] wr_data, // write data
  input  wire logic [7:0] rd_addr, // read address
  output logic      [7:0] rd_data  // read data
);

  logic [7:0] mem_ff [0:255];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 256; i++) begin
        mem_ff[i] <= `REG_RESET_VALUE;
      end
    end else if (wr_en) begin
      mem_ff[wr_addr] <= wr_data;
    end
  end

  assign rd_data = mem_ff[rd_addr];

endmodule : reg_space
`default_nettype wire

/* File: dv/fetch_model.sv */
// Purpose: fetch stage model offering decoded instructions
// Assumes: fields change on the falling clock edge only
// Notes:   released address, destination and literal fields carry inverted values
`timescale 1ns/1ps
`default_nettype none

module fetch_model (
  input  wire logic                   clk,         // instruction clock
  output var  logic                   instr_valid, // offer strobe
  output var  accum_exec_pkg::opcode_t instr_op,   // operation
  output var  logic [7:0]             instr_addr,  // register address
  output var  logic                   instr_dest,  // destination select
  output var  logic [7:0]             instr_lit    // literal
);
  initial begin
    instr_valid = 1'h0;
    instr_op    = accum_exec_pkg::OP_IDLE_INSTRUCTION;
    instr_addr  = 8'h00;
    instr_dest  = 1'h0;
    instr_lit   = 8'h00;
  end

  // ********************
  // driver tasks
  // ********************
  // offered at a falling edge, taken at the next rising edge
  task automatic issue(input logic [2:0] op, input logic [7:0] a, input logic d, input logic [7:0] k);
    instr_valid = 1'h1;
    instr_op    = accum_exec_pkg::opcode_t'(op);
    instr_addr  = a;
    instr_dest  = d;
    instr_lit   = k;
    @(negedge clk);
  endtask : issue

  // stale address, destination and literal fields flip so a lingering value never looks valid
  task automatic quiet();
    instr_valid = 1'h0;
    instr_addr  = ~instr_addr;
    instr_dest  = ~instr_dest;
    instr_lit   = ~instr_lit;
  endtask : quiet
endmodule : fetch_model
`default_nettype wire

/* File: dv/test_accumulator_move_or_execute.sv */
// Purpose: self-checking bench for the accumulator execute block
// Assumes: results visible one rising edge after an instruction is taken
// Notes:   register space observed through the peek port
`timescale 1ns/1ps
`default_nettype none

module test_accumulator_move_or_execute;
  logic                    clk, resetn, instr_valid, instr_dest;
  logic                    instr_ready, retire, zero_flag;
  accum_exec_pkg::opcode_t instr_op;
  logic [7:0]              instr_addr, instr_lit, dbg_addr, accum, dbg_data;
  int                      bad_count, cmp_count, cyc;
  localparam logic [2:0] op_or = accum_exec_pkg::OP_OR_ACCUM_WITH_REG;
  localparam logic [2:0] op_mr = accum_exec_pkg::OP_MOVE_REG_TO_ACCUM;
  localparam logic [2:0] op_ld = accum_exec_pkg::OP_LOAD_LITERAL_TO_ACCUM;
  localparam logic [2:0] op_st = accum_exec_pkg::OP_MOVE_ACCUM_TO_REG;

  fetch_model fetch (.clk(clk), .instr_valid(instr_valid), .instr_op(instr_op),
    .instr_addr(instr_addr), .instr_dest(instr_dest), .instr_lit(instr_lit));
  accum_exec DUT (.clk(clk), .resetn(resetn), .instr_valid(instr_valid), .instr_op(instr_op),
    .instr_addr(instr_addr), .instr_dest(instr_dest), .instr_lit(instr_lit), .dbg_addr(dbg_addr),
    .instr_ready(instr_ready), .retire(retire), .accum(accum), .zero_flag(zero_flag), .dbg_data(dbg_data));

  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  // ********************
  // helpers
  // ********************
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // one instruction; retire must stand in the cycle after the taking edge
  task automatic step(input logic [2:0] op, input logic [7:0] a, input logic d, input logic [7:0] k);
    fetch.issue(op, a, d, k);
    chk("retire", {7'h00, retire}, 8'h01);
  endtask : step

  task automatic peek(input logic [7:0] a, input logic [7:0] e);
    fetch.quiet();
    dbg_addr = a;
    @(negedge clk);
    chk("reg", dbg_data, e);
  endtask : peek

  task automatic acc_z(input logic [7:0] a, input logic z);
    chk("accum", accum, a);
    chk("zero", {7'h00, zero_flag}, {7'h00, z});
  endtask : acc_z

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict

  // ********************
  // scenarios
  // ********************
  task automatic t_load();
    step(op_ld, 8'h00, 1'h0, 8'h23);
    acc_z(8'h23, 1'h0);
    step(op_ld, 8'h00, 1'h0, 8'h00);
    acc_z(8'h00, 1'h0);
    $display("done load");
  endtask : t_load

  task automatic t_store();
    step(op_ld, 8'h00, 1'h0, 8'h23);
    step(op_st, 8'h10, 1'h0, 8'h00);
    acc_z(8'h23, 1'h0);
    step(op_st, 8'hFF, 1'h0, 8'h00);
    peek(8'h10, 8'h23);
    peek(8'hFF, 8'h23);
    $display("done store");
  endtask : t_store

  task automatic t_or();
    step(op_ld, 8'h00, 1'h0, 8'h88);
    step(op_or, 8'h10, 1'h0, 8'h00);
    acc_z(8'hAB, 1'h0);
    peek(8'h10, 8'h23);
    step(op_ld, 8'h00, 1'h0, 8'h88);
    step(op_or, 8'h10, 1'h1, 8'h00);
    acc_z(8'h88, 1'h0);
    peek(8'h10, 8'hAB);
    step(op_ld, 8'h00, 1'h0, 8'h00);
    step(op_or, 8'h20, 1'h1, 8'h00);
    acc_z(8'h00, 1'h1);
    peek(8'h20, 8'h00);
    $display("done or");
  endtask : t_or

  task automatic t_move();
    step(op_mr, 8'h10, 1'h0, 8'h00);
    acc_z(8'hAB, 1'h1);
    step(op_ld, 8'h00, 1'h0, 8'h5A);
    acc_z(8'h5A, 1'h1);
    step(op_or, 8'h20, 1'h0, 8'h00);
    acc_z(8'h5A, 1'h0);
    $display("done move");
  endtask : t_move

  task automatic t_idle();
    for (int i = 0; i < 8; i++) begin
      if (i == 0 || i > 4)
        step(i[2:0], 8'h10, 1'h1, 8'hFF);
      if (i == 0 || i > 4)
        acc_z(8'h5A, 1'h0);
    end
    peek(8'h10, 8'hAB);
    chk("retire", {7'h00, retire}, 8'h00);
    $display("done idle");
  endtask : t_idle

  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      give_verdict();
    end
  end

  initial begin
    resetn   = 1'h0;
    dbg_addr = 8'h00;
    repeat (8) @(negedge clk);
    resetn = 1'h1;
    acc_z(8'h00, 1'h0);
    chk("ready", {7'h00, instr_ready}, 8'h01);
    t_load();
    t_store();
    t_or();
    t_move();
    t_idle();
    give_verdict();
  end
endmodule : test_accumulator_move_or_execute
`default_nettype wire
